/* File: ccfg_pkg.sv */
// constants shared by the coherency unit configuration register bank
package ccfg_pkg;
    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_UNIT_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_UNIT_CONFIGURATION = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CPU_POWER_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INVALIDATE_ALL_WAYS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_FILTER_START_ADDRESS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FILTER_END_ADDRESS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_COMPONENT_ACCESS_CONTROL = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_NONSECURE_ACCESS_CONTROL = 8'h1c;

    // ************************************************************
    // unit_control bit positions
    // ************************************************************
    localparam int CTL_UNIT_EN = 0;
    localparam int CTL_FILTER_EN = 1;
    localparam int CTL_PARITY_EN = 2;
    localparam int CTL_SPEC_LINEFILL = 3;
    localparam int CTL_FORCE_PORT0 = 4;
    localparam int CTL_UNIT_STANDBY = 5;
    localparam int CTL_IRQ_CTRL_STANDBY = 6;

    // ************************************************************
    // field layouts
    // ************************************************************
    localparam int CFG_CPU_COUNT_LSB = 0;
    localparam int CFG_SMP_LSB = 4;
    localparam int CFG_TAG0_LSB = 8;
    localparam int CFG_TAG1_LSB = 10;
    localparam int PWR_CPU0_LSB = 0;
    localparam int PWR_CPU1_LSB = 8;
    localparam int INV_CPU0_LSB = 0;
    localparam int INV_CPU1_LSB = 4;
    localparam int FILT_LSB = 20;
    localparam int FILT_W = 12;
    localparam int NSAC_W = 12;
    localparam int WAYS_W = 4;

    // ************************************************************
    // encodings and reset values
    // ************************************************************
    localparam logic [1:0] CPU_COUNT_ONE = 2'h0;
    localparam logic [1:0] CPU_COUNT_TWO = 2'h1;
    localparam logic [1:0] TAG_16KB = 2'h0;
    localparam logic [1:0] TAG_32KB = 2'h1;
    localparam logic [1:0] TAG_64KB = 2'h2;
    localparam logic [3:0] AXCACHE_NC_BUF = 4'h1;
    localparam logic [3:0] AXCACHE_CLASS_MASK = 4'h3;
    localparam logic [1:0] ACCESS_RESET = 2'h0;
endpackage

/* File: ccfg_regs.sv */
// coherency unit control and configuration register bank
// Summary of operation
// RL1 - irq controller clock stops when standby enabled, no irq pending, no request outstanding
// RL2 - unit clock stops when standby enabled, all cores waiting and unit idle
// RL3 - with bit 4 set, non-cacheable bufferable requests go to master port zero
// RL4 - bit 3 set issues linefills speculatively; a lookup miss sends the confirmed linefill
// RL5 - bit 2 turns ram parity on; resets off; reads zero without parity support
// RL6 - bit 1 enables address filtering; reset value taken from the filter enable pin
// RL7 - bit 0 enables the coherency unit; unit comes out of reset disabled
// RL8 - tag ram size: second core bits 11:10, first core bits 9:8
// RL9 - smp participation bits 4 and 5 for first and second core
// RL10 - processor count reads b00 for one core, b01 for two
// RL11 - writing invalidate register invalidates chosen ways of each core
// RL12 - with fewer than two cores second core way bits are ignored
// RL13 - filter start bits 31:20 give region start at 1MB granularity
// RL14 - filter start resets to the value on the filter start pins
// RL15 - filter end bits 31:20 give region end; resets from filter end pins
// RL16 - access control bits 0 and 1 grant component access per core
// RL17 - reserved bits read zero and ignore writes
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
module ccfg_regs #(
    parameter int NUM_CPUS = 2,
    parameter bit PARITY_PRESENT = 1'b1
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [ccfg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [ccfg_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [ccfg_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_filter_enable_input,
    input wire logic [ccfg_pkg::FILT_W-1:0] i_filter_start_input,
    input wire logic [ccfg_pkg::FILT_W-1:0] i_filter_end_input,
    input wire logic [1:0] i_wait_for_interrupt_state,
    input wire logic i_unit_idle,
    input wire logic i_irq_pending,
    input wire logic i_cpu_req_outstanding,
    input wire logic i_req_valid,
    input wire logic [3:0] i_req_axcache,
    input wire logic i_lookup_start,
    input wire logic i_lookup_miss,
    output logic o_unit_enable,
    output logic o_filter_enable,
    output logic o_parity_enable,
    output logic [ccfg_pkg::FILT_W-1:0] o_filter_start,
    output logic [ccfg_pkg::FILT_W-1:0] o_filter_end,
    output logic o_unit_clock_run,
    output logic o_irq_ctrl_clock_run,
    output logic o_req_to_master_port_zero,
    output logic o_spec_linefill,
    output logic o_confirmed_linefill,
    output logic [1:0] o_smp_participation,
    output logic [3:0] o_tag_ram_size,
    output logic o_invalidate,
    output logic [ccfg_pkg::WAYS_W-1:0] o_first_core_way_select,
    output logic [ccfg_pkg::WAYS_W-1:0] o_second_core_way_select,
    output logic [1:0] o_component_access
);
    import ccfg_pkg::*;

    // ************************************************************
    // storage
    // ************************************************************
    localparam logic TWO_CORES = (NUM_CPUS > 1);
    localparam logic [1:0] PRESENT_MASK = TWO_CORES ? 2'h3 : 2'h1;

    logic [6:0] ctrl;
    logic [1:0] tag0;
    logic [1:0] tag1;
    logic [1:0] smp;
    logic [1:0] first_core_power_state;
    logic [1:0] second_core_power_state;
    logic [FILT_W-1:0] filt_start;
    logic [FILT_W-1:0] filt_end;
    logic [1:0] access;
    logic [NSAC_W-1:0] nsac;
    logic load_pending;
    logic fen_s1, fen_s2;
    logic [FILT_W-1:0] fst_s1, fst_s2;
    logic [FILT_W-1:0] fend_s1, fend_s2;
    logic [DATA_W-1:0] next_rdata;

    wire logic wr_ctrl = i_wr && (i_addr == OFS_UNIT_CONTROL);
    wire logic wr_start = i_wr && (i_addr == OFS_FILTER_START_ADDRESS);
    wire logic wr_end = i_wr && (i_addr == OFS_FILTER_END_ADDRESS);
    wire logic wr_inv = i_wr && (i_addr == OFS_INVALIDATE_ALL_WAYS);

    // ************************************************************
    // strap pin synchronisers
    // ************************************************************
    // pins are not reset: they must settle while reset is held
    always_ff @(posedge i_clk_sys) begin
        fen_s1 <= i_filter_enable_input;
        fen_s2 <= fen_s1;
        fst_s1 <= i_filter_start_input;
        fst_s2 <= fst_s1;
        fend_s1 <= i_filter_end_input;
        fend_s2 <= fend_s1;
    end

    // one cycle after release the synchronised straps are loaded
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            load_pending <= 1'b1;
        end else begin
            load_pending <= 1'b0;
        end
    end

    // ************************************************************
    // control register
    // ************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ctrl <= 7'h00; // unit disabled, parity off [RL7] [RL5]
        end else if (load_pending) begin
            ctrl[CTL_FILTER_EN] <= fen_s2; // [RL6]
        end else if (wr_ctrl) begin
            ctrl <= i_wdata[6:0]; // bits above 6 dropped [RL17]
            ctrl[CTL_PARITY_EN] <= PARITY_PRESENT & i_wdata[CTL_PARITY_EN]; // [RL5]
        end
    end

    // filter region bounds, loaded from straps at release
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            filt_start <= 12'h000;
            filt_end <= 12'h000;
        end else if (load_pending) begin
            filt_start <= fst_s2; // [RL14]
            filt_end <= fend_s2; // [RL15]
        end else begin
            if (wr_start) begin
                filt_start <= i_wdata[FILT_LSB +: FILT_W]; // [RL13]
            end
            if (wr_end) begin
                filt_end <= i_wdata[FILT_LSB +: FILT_W]; // [RL15]
            end
        end
    end

    // configuration, power status and access control fields
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            tag0 <= TAG_16KB;
            tag1 <= TAG_16KB;
            smp <= 2'h0;
            first_core_power_state <= 2'h0;
            second_core_power_state <= 2'h0;
            access <= ACCESS_RESET;
            nsac <= 12'h000;
        end else if (i_wr) begin
            if (i_addr == OFS_UNIT_CONFIGURATION) begin
                tag0 <= i_wdata[CFG_TAG0_LSB +: 2]; // [RL8]
                tag1 <= TWO_CORES ? i_wdata[CFG_TAG1_LSB +: 2] : TAG_16KB; // [RL8]
                smp <= i_wdata[CFG_SMP_LSB +: 2] & PRESENT_MASK; // [RL9]
            end else if (i_addr == OFS_CPU_POWER_STATUS) begin
                first_core_power_state <= i_wdata[PWR_CPU0_LSB +: 2];
                second_core_power_state <= i_wdata[PWR_CPU1_LSB +: 2];
            end else if (i_addr == OFS_COMPONENT_ACCESS_CONTROL) begin
                access <= i_wdata[1:0] & PRESENT_MASK; // [RL16]
            end else if (i_addr == OFS_NONSECURE_ACCESS_CONTROL) begin
                nsac <= i_wdata[NSAC_W-1:0];
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    // reserved bits and the invalidate register read zero [RL17]
    always_comb begin
        next_rdata = '0;
        if (i_addr == OFS_UNIT_CONTROL) begin
            next_rdata[6:0] = ctrl;
        end else if (i_addr == OFS_UNIT_CONFIGURATION) begin
            next_rdata[CFG_CPU_COUNT_LSB +: 2] = TWO_CORES ? CPU_COUNT_TWO : CPU_COUNT_ONE; // [RL10]
            next_rdata[CFG_SMP_LSB +: 2] = smp; // [RL9]
            next_rdata[CFG_TAG0_LSB +: 2] = tag0; // [RL8]
            next_rdata[CFG_TAG1_LSB +: 2] = tag1; // [RL8]
        end else if (i_addr == OFS_CPU_POWER_STATUS) begin
            next_rdata[PWR_CPU0_LSB +: 2] = first_core_power_state;
            next_rdata[PWR_CPU1_LSB +: 2] = second_core_power_state;
        end else if (i_addr == OFS_FILTER_START_ADDRESS) begin
            next_rdata[FILT_LSB +: FILT_W] = filt_start;
        end else if (i_addr == OFS_FILTER_END_ADDRESS) begin
            next_rdata[FILT_LSB +: FILT_W] = filt_end;
        end else if (i_addr == OFS_COMPONENT_ACCESS_CONTROL) begin
            next_rdata[1:0] = access;
        end else if (i_addr == OFS_NONSECURE_ACCESS_CONTROL) begin
            next_rdata[NSAC_W-1:0] = nsac;
        end
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= '0;
        end
    end

    // ************************************************************
    // invalidate-all pulse
    // ************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_invalidate <= 1'b0;
            o_first_core_way_select <= 4'h0;
            o_second_core_way_select <= 4'h0;
        end else begin
            o_invalidate <= wr_inv; // [RL11]
            if (wr_inv) begin
                o_first_core_way_select <= i_wdata[INV_CPU0_LSB +: WAYS_W]; // [RL11]
                // single core builds drop the second core ways [RL12]
                o_second_core_way_select <= TWO_CORES ? i_wdata[INV_CPU1_LSB +: WAYS_W] : 4'h0;
            end
        end
    end

    // ************************************************************
    // clock gating
    // ************************************************************
    // absent cores count as waiting so a single core build can gate
    wire logic all_waiting = &(i_wait_for_interrupt_state | ~PRESENT_MASK);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_unit_clock_run <= 1'b1;
            o_irq_ctrl_clock_run <= 1'b1;
        end else begin
            o_unit_clock_run <= !(ctrl[CTL_UNIT_STANDBY] && all_waiting && i_unit_idle); // [RL2]
            o_irq_ctrl_clock_run <= !(ctrl[CTL_IRQ_CTRL_STANDBY] && !i_irq_pending
                                      && !i_cpu_req_outstanding); // [RL1]
        end
    end

    // ************************************************************
    // request routing and linefills
    // ************************************************************
    // one cycle of latency is traded for a registered output
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_req_to_master_port_zero <= 1'b0;
            o_spec_linefill <= 1'b0;
            o_confirmed_linefill <= 1'b0;
        end else begin
            o_req_to_master_port_zero <= ctrl[CTL_FORCE_PORT0] && i_req_valid
                && ((i_req_axcache & AXCACHE_CLASS_MASK) == AXCACHE_NC_BUF); // [RL3]
            o_spec_linefill <= ctrl[CTL_SPEC_LINEFILL] && i_lookup_start; // [RL4]
            o_confirmed_linefill <= ctrl[CTL_SPEC_LINEFILL] && i_lookup_miss; // [RL4]
        end
    end

    // ************************************************************
    // configuration outputs
    // ************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_unit_enable <= 1'b0;
            o_filter_enable <= 1'b0;
            o_parity_enable <= 1'b0;
            o_filter_start <= 12'h000;
            o_filter_end <= 12'h000;
            o_smp_participation <= 2'h0;
            o_tag_ram_size <= 4'h0;
            o_component_access <= ACCESS_RESET;
        end else begin
            o_unit_enable <= ctrl[CTL_UNIT_EN]; // [RL7]
            o_filter_enable <= ctrl[CTL_FILTER_EN]; // [RL6]
            o_parity_enable <= ctrl[CTL_PARITY_EN]; // [RL5]
            o_filter_start <= filt_start; // [RL13]
            o_filter_end <= filt_end; // [RL15]
            o_smp_participation <= smp; // [RL9]
            o_tag_ram_size <= {tag1, tag0}; // [RL8]
            o_component_access <= access; // [RL16]
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    sequence s_ctrl_write(int b);
        wr_ctrl && !load_pending ##1 1'b1;
    endsequence

    chk_unit_enable_follow: assert property (s_ctrl_write(0) |=> o_unit_enable == $past(i_wdata[0], 2)) // [RL7]
        else $error("unit enable does not follow control write");
    chk_parity_absent_zero: assert property (s_ctrl_write(0)
        |-> ctrl[CTL_PARITY_EN] == (PARITY_PRESENT && $past(i_wdata[CTL_PARITY_EN]))) // [RL5]
        else $error("parity bit does not follow control write");
    chk_filter_en_strap: assert property ($fell(load_pending) |-> ctrl[CTL_FILTER_EN] == $past(fen_s2)) // [RL6]
        else $error("filter enable not loaded from strap");
    chk_filter_start_strap: assert property ($fell(load_pending) |-> filt_start == $past(fst_s2)) // [RL14]
        else $error("filter start not loaded from strap");
    chk_filter_end_strap: assert property ($fell(load_pending) |-> filt_end == $past(fend_s2)) // [RL15]
        else $error("filter end not loaded from strap");
    chk_unit_gate_off: assert property (ctrl[CTL_UNIT_STANDBY] && all_waiting && i_unit_idle |=> !o_unit_clock_run) // [RL2]
        else $error("unit clock not gated");
    chk_unit_gate_wake: assert property (!all_waiting |=> o_unit_clock_run) // [RL2]
        else $error("unit clock not restarted on wake");
    chk_irq_gate: assert property (ctrl[CTL_IRQ_CTRL_STANDBY] && (i_irq_pending || i_cpu_req_outstanding)
        |=> o_irq_ctrl_clock_run) // [RL1]
        else $error("irq controller clock stopped while busy");
    chk_port_zero_route: assert property (ctrl[CTL_FORCE_PORT0] && i_req_valid && i_req_axcache == AXCACHE_NC_BUF
        |=> o_req_to_master_port_zero) // [RL3]
        else $error("bufferable request not routed to port zero");
    chk_confirmed_fill: assert property (!ctrl[CTL_SPEC_LINEFILL] |=> !o_spec_linefill && !o_confirmed_linefill) // [RL4]
        else $error("linefill issued with speculation off");
    chk_cpu_count_read: assert property (i_rd && i_addr == OFS_UNIT_CONFIGURATION
        |=> o_rdata[1:0] == (TWO_CORES ? CPU_COUNT_TWO : CPU_COUNT_ONE)) // [RL10]
        else $error("processor count reads wrong");
    chk_invalidate_pulse: assert property (wr_inv |=> o_invalidate && o_first_core_way_select == $past(i_wdata[3:0])
        ##1 !o_invalidate || $past(wr_inv)) // [RL11]
        else $error("invalidate pulse or ways wrong");
    chk_second_ways_drop: assert property (wr_inv
        |=> o_second_core_way_select == (TWO_CORES ? $past(i_wdata[INV_CPU1_LSB +: WAYS_W]) : 4'h0)) // [RL12]
        else $error("second core ways wrong for this build");
    chk_reserved_ctrl: assert property (i_rd && i_addr == OFS_UNIT_CONTROL |=> o_rdata[DATA_W-1:7] == '0) // [RL17]
        else $error("reserved control bits read nonzero");
    chk_rdata_one_cycle: assert property (!i_rd |=> o_rdata == '0) // [RL17]
        else $error("read data held beyond its cycle");
    chk_access_follow: assert property (i_wr && i_addr == OFS_COMPONENT_ACCESS_CONTROL
        |=> ##1 o_component_access == ($past(i_wdata[1:0], 2) & PRESENT_MASK)) // [RL16]
        else $error("access control output wrong");
endmodule // ccfg_regs

/* File: ccfg_core_side.sv */
// behavioural model of the cores and level-two controller facing the register bank
`timescale 1ns/1ns
module ccfg_core_side (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [31:0] i_rand,
    output logic [1:0] o_wait_for_interrupt_state,
    output logic o_unit_idle,
    output logic o_irq_pending,
    output logic o_cpu_req_outstanding,
    output logic o_req_valid,
    output logic [3:0] o_req_axcache,
    output logic o_lookup_start,
    output logic o_lookup_miss
);
    // ************************************************************
    // core activity, refreshed every cycle from the bench's random word
    // ************************************************************
    // bits are or-ed and and-ed so that the rare idle cases still show up often
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_wait_for_interrupt_state <= 2'h0;
            o_unit_idle <= 1'b0;
            o_irq_pending <= 1'b0;
            o_cpu_req_outstanding <= 1'b0;
            o_req_valid <= 1'b0;
            o_req_axcache <= 4'h0;
            o_lookup_start <= 1'b0;
            o_lookup_miss <= 1'b0;
        end else begin
            o_wait_for_interrupt_state <= i_rand[1:0] | {2{i_rand[2]}};
            o_unit_idle <= i_rand[3] | i_rand[4];
            o_irq_pending <= i_rand[5] & i_rand[6];
            o_cpu_req_outstanding <= i_rand[7] & i_rand[8];
            o_req_valid <= i_rand[9];
            o_req_axcache <= i_rand[13:10];
            o_lookup_start <= i_rand[14] & ~o_lookup_start;
            o_lookup_miss <= o_lookup_start & i_rand[15]; // a miss only answers a lookup begun just before
        end
    end
endmodule // ccfg_core_side

/* File: ccfg_regs_bench.sv */
// self-checking bench for the coherency unit configuration register bank
`timescale 1ns/1ns
module ccfg_regs_bench;
    import ccfg_pkg::*;
    logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, fen = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, core_rand = 32'h0, seed = 32'h56, o_rdata;
    logic [11:0] fst = 12'h123, fend = 12'habc, o_fs, o_fe;
    logic [1:0] wait_for_interrupt_state, o_smp, o_acc;
    logic idle, irqp, outst, rqv, lks, lkm, o_ue, o_fen, o_pe, o_ucr, o_icr, o_p0, o_sl, o_cl, o_inv;
    logic [3:0] axc, o_tag, o_w0, o_w1;
    int miscompares = 0, n_compared = 0, mon_cnt = 0;
    // model state and the outputs expected after the coming edge
    logic [31:0] m_ctrl, m_cfg, m_pwr, m_sac, m_nsac, e_rd;
    logic [11:0] m_fs, m_fe, e_fs, e_fe;
    logic [3:0] m_w0, m_w1, e_w0, e_w1, e_tag;
    logic [1:0] e_smp, e_acc;
    logic e_ue, e_fen, e_pe, e_ucr, e_icr, e_p0, e_sl, e_cl, e_inv;

    initial begin
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    ccfg_core_side far (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_rand(core_rand),
        .o_wait_for_interrupt_state(wait_for_interrupt_state), .o_unit_idle(idle), .o_irq_pending(irqp),
        .o_cpu_req_outstanding(outst), .o_req_valid(rqv), .o_req_axcache(axc),
        .o_lookup_start(lks), .o_lookup_miss(lkm));

    ccfg_regs uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_filter_enable_input(fen),
        .i_filter_start_input(fst), .i_filter_end_input(fend), .i_wait_for_interrupt_state(wait_for_interrupt_state),
        .i_unit_idle(idle), .i_irq_pending(irqp), .i_cpu_req_outstanding(outst), .i_req_valid(rqv),
        .i_req_axcache(axc), .i_lookup_start(lks), .i_lookup_miss(lkm), .o_unit_enable(o_ue),
        .o_filter_enable(o_fen), .o_parity_enable(o_pe), .o_filter_start(o_fs), .o_filter_end(o_fe),
        .o_unit_clock_run(o_ucr), .o_irq_ctrl_clock_run(o_icr), .o_req_to_master_port_zero(o_p0),
        .o_spec_linefill(o_sl), .o_confirmed_linefill(o_cl), .o_smp_participation(o_smp),
        .o_tag_ram_size(o_tag), .o_invalidate(o_inv), .o_first_core_way_select(o_w0),
        .o_second_core_way_select(o_w1), .o_component_access(o_acc));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // model view of a register read; unmapped and unaligned places read zero
    function automatic logic [31:0] m_read(input logic [7:0] a);
        case (a)
            OFS_UNIT_CONTROL: return m_ctrl;
            OFS_UNIT_CONFIGURATION: return m_cfg | 32'h1;
            OFS_CPU_POWER_STATUS: return m_pwr;
            OFS_FILTER_START_ADDRESS: return {m_fs, 20'h0};
            OFS_FILTER_END_ADDRESS: return {m_fe, 20'h0};
            OFS_COMPONENT_ACCESS_CONTROL: return m_sac;
            OFS_NONSECURE_ACCESS_CONTROL: return m_nsac;
            default: return 32'h0;
        endcase
    endfunction

    // ************************************************************
    // reference model, compared with the design at every edge from the third after release
    // ************************************************************
    // outputs seen before an edge were launched by the previous edge, so compare first, then predict
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            m_ctrl = {30'h0, fen, 1'b0};
            {m_cfg, m_pwr, m_sac, m_nsac, m_w0, m_w1} = '0;
            m_fs = fst;
            m_fe = fend;
            mon_cnt = 0;
        end else begin
            if (mon_cnt >= 2) begin
                check("read data", o_rdata, e_rd);
                check("unit enable", o_ue, e_ue);
                check("filter enable", o_fen, e_fen);
                check("parity enable", o_pe, e_pe);
                check("filter start", o_fs, e_fs);
                check("filter end", o_fe, e_fe);
                check("unit clock run", o_ucr, e_ucr);
                check("irq clock run", o_icr, e_icr);
                check("port zero route", o_p0, e_p0);
                check("spec linefill", o_sl, e_sl);
                check("confirmed linefill", o_cl, e_cl);
                check("smp", o_smp, e_smp);
                check("tag size", o_tag, e_tag);
                check("invalidate", o_inv, e_inv);
                check("ways first", o_w0, e_w0);
                check("ways second", o_w1, e_w1);
                check("access", o_acc, e_acc);
            end
            e_rd = i_rd ? m_read(i_addr) : 32'h0;
            {e_ue, e_fen, e_pe} = {m_ctrl[0], m_ctrl[1], m_ctrl[2]};
            {e_fs, e_fe, e_smp, e_tag, e_acc} = {m_fs, m_fe, m_cfg[5:4], m_cfg[11:8], m_sac[1:0]};
            e_ucr = !(m_ctrl[5] && wait_for_interrupt_state == 2'h3 && idle);
            e_icr = !(m_ctrl[6] && !irqp && !outst);
            e_p0 = m_ctrl[4] && rqv && axc[1:0] == 2'h1;
            e_sl = m_ctrl[3] && lks;
            e_cl = m_ctrl[3] && lkm;
            e_inv = i_wr && i_addr == OFS_INVALIDATE_ALL_WAYS;
            if (e_inv) {m_w1, m_w0} = i_wdata[7:0];
            {e_w1, e_w0} = {m_w1, m_w0};
            if (i_wr) begin
                case (i_addr)
                    OFS_UNIT_CONTROL: m_ctrl = i_wdata & 32'h7f;
                    OFS_UNIT_CONFIGURATION: m_cfg = i_wdata & 32'hf30;
                    OFS_CPU_POWER_STATUS: m_pwr = i_wdata & 32'h303;
                    OFS_FILTER_START_ADDRESS: m_fs = i_wdata[31:20];
                    OFS_FILTER_END_ADDRESS: m_fe = i_wdata[31:20];
                    OFS_COMPONENT_ACCESS_CONTROL: m_sac = i_wdata & 32'h3;
                    OFS_NONSECURE_ACCESS_CONTROL: m_nsac = i_wdata & 32'hfff;
                    default: ;
                endcase
            end
            mon_cnt++;
        end
    end

    // ************************************************************
    // stimulus
    // ************************************************************
    // reset long enough for the strap synchronisers to fill; requests start at edge 2 after release
    task automatic apply_reset();
        i_sys_rst <= 1'b1;
        {i_wr, i_rd} <= 2'h0;
        repeat (2) @(posedge i_clk_sys);
        #1;
        check("reset unit enable", o_ue, 1'b0);
        check("reset parity", o_pe, 1'b0);
        check("reset clock run", {o_ucr, o_icr}, 2'h3);
        @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        @(posedge i_clk_sys);
        for (int a = 0; a < 9; a++) begin
            @(posedge i_clk_sys);
            i_rd <= 1'b1;
            i_addr <= 8'(a * 4);
        end
    endtask

    // random mix of reads, writes and idle cycles, back to back, with unmapped places among them
    task automatic run(input int n);
        logic [31:0] r;
        repeat (n) begin
            @(posedge i_clk_sys);
            r = xs();
            i_wr <= r[1:0] == 2'h1;
            i_rd <= r[1:0] == 2'h2;
            i_addr <= r[16] ? r[13:6] : {2'h0, r[5:2], 2'h0};
            i_wdata <= xs();
            core_rand <= xs();
        end
    endtask

    task automatic results();
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        apply_reset();
        run(800);
        @(posedge i_clk_sys);
        fen <= 1'b0;
        fst <= 12'hf01;
        fend <= 12'h05e;
        apply_reset(); // second reset with other straps in mid-run
        run(800);
        @(posedge i_clk_sys);
        {i_wr, i_rd} <= 2'h0;
        repeat (3) @(posedge i_clk_sys);
        results();
    end

    // watchdog, well beyond the roughly 1630 cycles the sequence needs
    initial begin
        #(50 * 5000);
        miscompares++;
        results();
    end
endmodule // ccfg_regs_bench
